// file: pkg/lmsc_cfg.svh
`ifndef LMSC_CFG_SVH
`define LMSC_CFG_SVH
// Register offsets
`define LMSC_OFS_STATUS   4'h0
`define LMSC_OFS_DATA     4'h1
`define LMSC_OFS_BAUD     4'h2
`define LMSC_OFS_RX_EXT   4'h3
`define LMSC_OFS_TX_EXT   4'h4
`define LMSC_OFS_CTRL1    4'h5
`define LMSC_OFS_CTRL2    4'h6
`define LMSC_OFS_CTRL3    4'h7
`define LMSC_OFS_LIN_MANT 4'h8
`define LMSC_OFS_LIN_FRAC 4'h9
// Control one bits
`define LMSC_C1_WLEN 4
`define LMSC_C1_PCE  2
// Control two bits
`define LMSC_C2_RIE  5
`define LMSC_C2_TE   3
`define LMSC_C2_RE   2
`define LMSC_C2_SBK  0
// Control three bits
`define LMSC_C3_LINE 7
`define LMSC_C3_LIN_SLAVE_SELECT 6
`define LMSC_C3_AUTO_RESYNC_ENABLE 5
`define LMSC_C3_HEADER_DETECT_METHOD 4
`define LMSC_C3_HEADER_IRQ_ENABLE 3
`define LMSC_C3_HEADER_DETECTED_FLAG 2
`define LMSC_C3_LSF  1
// Status bits
`define LMSC_SR_TX_DATA_EMPTY_FLAG 7
`define LMSC_SR_RX_DATA_FULL_FLAG 5
`define LMSC_SR_OR   3
`define LMSC_SR_LHE  2
`define LMSC_SR_FE   1
`define LMSC_SR_PE   0
// Reset values
`define LMSC_RST_BYTE 8'h00
`define LMSC_RST_BAUD_DIVIDER 12'h010
// Timing
`define LMSC_OVS          16
`define LMSC_HDR_MAX_BITS 57
`define LMSC_BRK_BITS     13
`define LMSC_SYNC_BYTE    8'h55
`define LMSC_SYNC_BITS    8
`endif

// file: pkg/lmsc_pkg.sv
package lmsc_pkg;
  typedef enum logic [2:0] {LMSC_R_IDLE, LMSC_R_DATA, LMSC_R_WAIT, LMSC_R_MEAS, LMSC_R_BLOCK} lmsc_rx_st_t;
  typedef enum logic [1:0] {LMSC_T_IDLE, LMSC_T_DATA, LMSC_T_BRK} lmsc_tx_st_t;
  typedef enum logic [1:0] {LMSC_H_NONE, LMSC_H_SYNC, LMSC_H_ID} lmsc_hdr_t;
  typedef struct packed {
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_prev;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  ctrl3;
    logic [7:0]  baud;
    logic [7:0]  rx_ext;
    logic [7:0]  tx_ext;
    logic [11:0] baud_divider;
    logic [7:0]  rx_data;
    logic [7:0]  tx_data;
    logic        tx_data_empty_flag;
    logic        rx_data_full_flag;
    logic        ovr;
    logic        header_error_flag;
    logic        fe;
    logic        pe;
    logic        sr_seen;
    logic        brk_pend;
    logic [19:0] rx_cnt;
    logic [19:0] tx_cnt;
    lmsc_rx_st_t rx_st;
    logic [3:0]  rx_smp;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_sh;
    lmsc_tx_st_t tx_st;
    logic [3:0]  tx_smp;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    lmsc_hdr_t   hdr;
    logic        tmo_on;
    logic [10:0] tmo;
    logic [14:0] meas;
    logic [14:0] seg;
    logic [2:0]  edges;
    logic        seg_short;
    logic        tx;
    logic        irq;
    logic [7:0]  rdata;
  } lmsc_state_t;
endpackage

// file: src/lmsc_lin_serial.sv
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`include "lmsc_cfg.svh"
// Behaviour
// - Nonzero transmit extended prescaler divides the by-16 clock by its value.
// - Transmit extended prescaler resets to zero, extended generator off.
// - LIN slave uses one LIN generator for transmit and receive.
// - Master mode send break emits thirteen low bit times.
// - Slave mode ignores send break, no break sent.
// - Master baud comes from conventional and extended prescalers.
// - Method zero break sets receive-full with 0x00 and header detected.
// - Header detected raises interrupt when enabled and CPU masks clear.
// - Auto-resync or method one hides synch field; otherwise it is a normal character.
// - Method one flags header detected and full after identifier arrives.
// - Receiver halted and nothing stored during synch measurement.
// - Slave framing error flag sets except for a break frame.
// - With parity check, second character after break (the identifier) has parity checked.
// - Header error raises interrupt when receive interrupt enable set, masks clear.
// - Blocked until synch-field flag cleared, then header error cleared.
// - Header error clears on status access followed by data read.
// - Without resync, bad synch, overrun, method one timeout flag error.
// - With resync, deviation, timeout, overruns, overflow flag error; overflow blocks.
// - Deviation above 15.625% or short synch bit sets error and blocks.
// - Header not complete within 57 bit times after break sets error; the timer runs only with method one or auto-resync.
// - Slave baud is CPU clock over sixteen times 8.4 fixed divider.
module lmsc_lin_serial (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [1:0] i_cpu_mask,
  input  wire logic       i_rx,
  output logic      [7:0] o_rdata,
  output logic            o_tx,
  output logic            o_irq
);

  lmsc_pkg::lmsc_state_t q;
  lmsc_pkg::lmsc_state_t d;

  function automatic logic [19:0] cyc_per_tick(input logic [1:0] pr, input logic [2:0] div, input logic [7:0] ext);
    logic [4:0]  f;
    logic [19:0] base;
    f = (pr == 2'h0) ? 5'h01 : (pr == 2'h1) ? 5'h03 : (pr == 2'h2) ? 5'h04 : 5'h0D;
    base = 20'(f) << div;
    cyc_per_tick = (ext == 8'h00) ? base : 20'(base * 20'(ext));
  endfunction

  function automatic logic id_parity_ok(input logic [7:0] b);
    logic p0;
    logic p1;
    p0 = b[0] ^ b[1] ^ b[2] ^ b[4];
    p1 = ~(b[1] ^ b[3] ^ b[4] ^ b[5]);
    id_parity_ok = (b[6] == p0) && (b[7] == p1);
  endfunction

  logic        line;
  logic        slave;
  logic        auto_resync_enable;
  logic        header_detect_method;
  logic        rx_tick;
  logic        tx_tick;
  logic [19:0] rx_div;
  logic [19:0] tx_div;
  logic        fall;
  logic [15:0] nom8;
  logic [15:0] dev;

  assign line  = q.ctrl3[`LMSC_C3_LINE];
  assign slave = line & q.ctrl3[`LMSC_C3_LIN_SLAVE_SELECT];
  assign auto_resync_enable  = q.ctrl3[`LMSC_C3_AUTO_RESYNC_ENABLE];
  assign header_detect_method  = q.ctrl3[`LMSC_C3_HEADER_DETECT_METHOD];
  assign rx_div = cyc_per_tick(q.baud[7:6], q.baud[2:0], q.rx_ext);
  assign tx_div = cyc_per_tick(q.baud[7:6], q.baud[5:3], q.tx_ext);
  assign fall = q.rx_prev & ~q.rx_s2;
  assign nom8 = {1'b0, q.baud_divider, 3'h0};
  assign dev  = ({1'b0, q.meas} > nom8) ? 16'({1'b0, q.meas} - nom8) : 16'(nom8 - {1'b0, q.meas});

  always_comb
  begin
    d = q;
    d.rx_s1   = i_rx;
    d.rx_s2   = q.rx_s1;
    d.rx_prev = q.rx_s2;
    d.rdata   = 8'h00;
    rx_tick   = 1'b0;
    tx_tick   = 1'b0;

    // Baud ticks at sixteen times the bit rate
    if (slave)
    begin
      if (q.rx_cnt + 20'(`LMSC_OVS) >= 20'(q.baud_divider))
      begin
        rx_tick  = 1'b1;
        d.rx_cnt = 20'(q.rx_cnt + 20'(`LMSC_OVS) - 20'(q.baud_divider));
      end
      else
        d.rx_cnt = 20'(q.rx_cnt + 20'(`LMSC_OVS));
      tx_tick  = rx_tick;
      d.tx_cnt = 20'h0;
    end
    else
    begin
      if (q.rx_cnt + 20'h1 >= rx_div)
      begin
        rx_tick  = 1'b1;
        d.rx_cnt = 20'h0;
      end
      else
        d.rx_cnt = 20'(q.rx_cnt + 20'h1);
      if (q.tx_cnt + 20'h1 >= tx_div)
      begin
        tx_tick  = 1'b1;
        d.tx_cnt = 20'h0;
      end
      else
        d.tx_cnt = 20'(q.tx_cnt + 20'h1);
    end

    // Register reads
    if (i_rd)
    begin
      d.sr_seen = 1'b0;
      if (i_addr == `LMSC_OFS_STATUS)
      begin
        d.rdata = {q.tx_data_empty_flag, 1'b0, q.rx_data_full_flag, 1'b0, q.ovr, q.header_error_flag, q.fe, q.pe};
        d.sr_seen = 1'b1;
      end
      else if (i_addr == `LMSC_OFS_DATA)
      begin
        d.rdata = q.rx_data;
        if (q.sr_seen)
        begin
          d.rx_data_full_flag = 1'b0;
          d.ovr  = 1'b0;
          d.fe   = 1'b0;
          d.pe   = 1'b0;
          if (!q.ctrl3[`LMSC_C3_LSF])
            d.header_error_flag = 1'b0;
        end
      end
      else if (i_addr == `LMSC_OFS_BAUD)
        d.rdata = q.baud;
      else if (i_addr == `LMSC_OFS_RX_EXT)
        d.rdata = q.rx_ext;
      else if (i_addr == `LMSC_OFS_TX_EXT)
        d.rdata = q.tx_ext;
      else if (i_addr == `LMSC_OFS_CTRL1)
        d.rdata = q.ctrl1;
      else if (i_addr == `LMSC_OFS_CTRL2)
        d.rdata = q.ctrl2;
      else if (i_addr == `LMSC_OFS_CTRL3)
        d.rdata = q.ctrl3;
      else if (i_addr == `LMSC_OFS_LIN_MANT)
        d.rdata = q.baud_divider[11:4];
      else if (i_addr == `LMSC_OFS_LIN_FRAC)
        d.rdata = {4'h0, q.baud_divider[3:0]};
    end

    // Register writes
    if (i_wr)
    begin
      if (i_addr == `LMSC_OFS_DATA)
      begin
        d.tx_data = i_wdata;
        d.tx_data_empty_flag    = 1'b0;
      end
      else if (i_addr == `LMSC_OFS_BAUD)
        d.baud = i_wdata;
      else if (i_addr == `LMSC_OFS_RX_EXT)
        d.rx_ext = i_wdata;
      else if (i_addr == `LMSC_OFS_TX_EXT)
        d.tx_ext = i_wdata;
      else if (i_addr == `LMSC_OFS_CTRL1)
        d.ctrl1 = i_wdata;
      else if (i_addr == `LMSC_OFS_CTRL2)
      begin
        d.ctrl2 = i_wdata;
        if (i_wdata[`LMSC_C2_SBK] && !slave)
          d.brk_pend = 1'b1;
      end
      else if (i_addr == `LMSC_OFS_CTRL3)
      begin
        d.ctrl3 = i_wdata;
        d.ctrl3[`LMSC_C3_HEADER_DETECTED_FLAG] = q.ctrl3[`LMSC_C3_HEADER_DETECTED_FLAG] & i_wdata[`LMSC_C3_HEADER_DETECTED_FLAG];
        d.ctrl3[`LMSC_C3_LSF]  = q.ctrl3[`LMSC_C3_LSF] & i_wdata[`LMSC_C3_LSF];
      end
      else if (i_addr == `LMSC_OFS_LIN_MANT)
        d.baud_divider[11:4] = i_wdata;
      else if (i_addr == `LMSC_OFS_LIN_FRAC)
        d.baud_divider[3:0] = i_wdata[3:0];
    end

    // Transmitter
    case (q.tx_st)
      lmsc_pkg::LMSC_T_IDLE:
      begin
        d.tx = 1'b1;
        if (q.ctrl2[`LMSC_C2_TE] && tx_tick)
        begin
          d.tx_smp = 4'h0;
          d.tx_bit = 4'h0;
          if (q.brk_pend && !slave)
          begin
            d.brk_pend = 1'b0;
            d.tx_st    = lmsc_pkg::LMSC_T_BRK;
          end
          else if (!q.tx_data_empty_flag)
          begin
            d.tx_sh = {1'b1, q.tx_data, 1'b0};
            d.tx_data_empty_flag  = 1'b1;
            d.tx_st = lmsc_pkg::LMSC_T_DATA;
          end
        end
      end
      lmsc_pkg::LMSC_T_DATA:
      begin
        d.tx = q.tx_sh[0];
        if (tx_tick)
        begin
          d.tx_smp = 4'(q.tx_smp + 4'h1);
          if (q.tx_smp == 4'hF)
          begin
            d.tx_sh  = {1'b1, q.tx_sh[9:1]};
            d.tx_bit = 4'(q.tx_bit + 4'h1);
            if (q.tx_bit == 4'h9)
              d.tx_st = lmsc_pkg::LMSC_T_IDLE;
          end
        end
      end
      lmsc_pkg::LMSC_T_BRK:
      begin
        d.tx = 1'b0;
        if (tx_tick)
        begin
          d.tx_smp = 4'(q.tx_smp + 4'h1);
          if (q.tx_smp == 4'hF)
          begin
            d.tx_bit = 4'(q.tx_bit + 4'h1);
            if (q.tx_bit == 4'(`LMSC_BRK_BITS - 1))
            begin
              d.tx_st = lmsc_pkg::LMSC_T_IDLE;
            end
          end
        end
      end
      default:
        d.tx_st = lmsc_pkg::LMSC_T_IDLE;
    endcase

    // Header timeout in baud ticks (sixteen per bit time) after the break
    if (q.tmo_on && rx_tick)
    begin
      d.tmo = 11'(q.tmo + 11'h1);
      if (q.tmo >= 11'(`LMSC_HDR_MAX_BITS * `LMSC_OVS))
      begin
        d.header_error_flag    = 1'b1;
        d.tmo_on = 1'b0;
        d.hdr    = lmsc_pkg::LMSC_H_NONE;
        if (q.rx_st == lmsc_pkg::LMSC_R_MEAS && auto_resync_enable)
        begin
          d.ctrl3[`LMSC_C3_LSF] = 1'b1;
          d.rx_st = lmsc_pkg::LMSC_R_BLOCK;
        end
      end
    end

    // Receiver
    case (q.rx_st)
      lmsc_pkg::LMSC_R_IDLE:
      begin
        if (q.ctrl2[`LMSC_C2_RE] && fall)
        begin
          d.rx_smp = 4'h0;
          d.rx_bit = 4'h0;
          d.meas   = 15'h0;
          d.seg    = 15'h0;
          d.edges  = 3'h1;
          d.seg_short = 1'b0;
          if (slave && auto_resync_enable && q.hdr == lmsc_pkg::LMSC_H_SYNC)
            d.rx_st = lmsc_pkg::LMSC_R_MEAS;
          else
            d.rx_st = lmsc_pkg::LMSC_R_DATA;
        end
      end
      lmsc_pkg::LMSC_R_DATA:
      begin
        if (rx_tick)
        begin
          d.rx_smp = 4'(q.rx_smp + 4'h1);
          if (q.rx_smp == 4'h8)
          begin
            d.rx_bit = 4'(q.rx_bit + 4'h1);
            if (q.rx_bit != 4'h0)
              d.rx_sh = {q.rx_s2, q.rx_sh[8:1]};
            if (q.rx_bit == 4'h9)
            begin
              d.rx_st = lmsc_pkg::LMSC_R_IDLE;
              if (!q.rx_s2 && q.rx_sh[8:1] == 8'h00 && line)
              begin
                d.rx_st = lmsc_pkg::LMSC_R_WAIT;
                if (slave)
                begin
                  d.hdr    = lmsc_pkg::LMSC_H_SYNC;
                  d.tmo_on = header_detect_method | auto_resync_enable;
                  d.tmo    = 11'h0;
                  if (!header_detect_method)
                  begin
                    d.rx_data = 8'h00;
                    d.rx_data_full_flag    = 1'b1;
                    d.ctrl3[`LMSC_C3_HEADER_DETECTED_FLAG] = 1'b1;
                  end
                end
              end
              else if (!q.rx_s2)
              begin
                d.fe    = 1'b1;
                d.rx_st = lmsc_pkg::LMSC_R_WAIT;
              end
              else
              begin
                if (slave && q.hdr == lmsc_pkg::LMSC_H_SYNC)
                begin
                  if (q.rx_sh[8:1] != `LMSC_SYNC_BYTE)
                  begin
                    d.header_error_flag    = 1'b1;
                    d.hdr    = lmsc_pkg::LMSC_H_NONE;
                    d.tmo_on = 1'b0;
                  end
                  else
                    d.hdr = lmsc_pkg::LMSC_H_ID;
                end
                else if (slave && q.hdr == lmsc_pkg::LMSC_H_ID)
                begin
                  d.hdr    = lmsc_pkg::LMSC_H_NONE;
                  d.tmo_on = 1'b0;
                  if (q.ctrl1[`LMSC_C1_PCE] && !id_parity_ok(q.rx_sh[8:1]))
                    d.pe = 1'b1;
                  if (header_detect_method)
                    d.ctrl3[`LMSC_C3_HEADER_DETECTED_FLAG] = 1'b1;
                end
                if (!(slave && header_detect_method && q.hdr == lmsc_pkg::LMSC_H_SYNC))
                begin
                  if (q.rx_data_full_flag && !(i_rd && i_addr == `LMSC_OFS_DATA && q.sr_seen))
                  begin
                    d.ovr = 1'b1;
                    if (line)
                      d.header_error_flag = 1'b1;
                  end
                  else
                  begin
                    d.rx_data = q.rx_sh[8:1];
                    d.rx_data_full_flag    = 1'b1;
                  end
                end
              end
            end
            else
              d.rx_smp = 4'h9;
          end
          else if (q.rx_smp == 4'hF)
            d.rx_smp = 4'h0;
        end
      end
      lmsc_pkg::LMSC_R_WAIT:
      begin
        if (q.rx_s2)
          d.rx_st = lmsc_pkg::LMSC_R_IDLE;
      end
      lmsc_pkg::LMSC_R_MEAS:
      begin
        d.meas = 15'(q.meas + 15'h1);
        d.seg  = 15'(q.seg + 15'h1);
        if (q.meas == 15'h7FFF)
        begin
          d.header_error_flag    = 1'b1;
          d.tmo_on = 1'b0;
          d.hdr    = lmsc_pkg::LMSC_H_NONE;
          d.ctrl3[`LMSC_C3_LSF] = 1'b1;
          d.rx_st  = lmsc_pkg::LMSC_R_BLOCK;
        end
        else if (fall)
        begin
          d.seg   = 15'h0;
          d.edges = 3'(q.edges + 3'h1);
          if ({q.seg, 5'h00} < 20'(q.baud_divider * 12'd54))
            d.seg_short = 1'b1;
          if (q.edges == 3'h4)
          begin
            if ({dev, 6'h00} > 22'(nom8 * 16'd10) || q.seg_short || {q.seg, 5'h00} < 20'(q.baud_divider * 12'd54))
            begin
              d.header_error_flag    = 1'b1;
              d.tmo_on = 1'b0;
              d.hdr    = lmsc_pkg::LMSC_H_NONE;
              d.ctrl3[`LMSC_C3_LSF] = 1'b1;
              d.rx_st  = lmsc_pkg::LMSC_R_BLOCK;
            end
            else
            begin
              if (!(i_wr && (i_addr == `LMSC_OFS_LIN_MANT || i_addr == `LMSC_OFS_LIN_FRAC)))
                d.baud_divider = 12'(q.meas >> 3);
              d.hdr   = lmsc_pkg::LMSC_H_ID;
              d.rx_st = lmsc_pkg::LMSC_R_WAIT;
            end
          end
        end
      end
      lmsc_pkg::LMSC_R_BLOCK:
      begin
        if (!q.ctrl3[`LMSC_C3_LSF] && !q.header_error_flag)
          d.rx_st = lmsc_pkg::LMSC_R_WAIT;
      end
      default:
        d.rx_st = lmsc_pkg::LMSC_R_IDLE;
    endcase

    // Interrupt request gated by CPU masks
    d.irq = (i_cpu_mask == 2'h0)
          && ((d.ctrl3[`LMSC_C3_HEADER_DETECTED_FLAG] && d.ctrl3[`LMSC_C3_HEADER_IRQ_ENABLE])
          || (q.ctrl2[`LMSC_C2_RIE] && (d.header_error_flag || d.rx_data_full_flag || d.ovr)));
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      q <= '0;
      q.rx_s1   <= 1'b1;
      q.rx_s2   <= 1'b1;
      q.rx_prev <= 1'b1;
      q.tx_ext  <= `LMSC_RST_BYTE;
      q.baud_divider    <= `LMSC_RST_BAUD_DIVIDER;
      q.tx_data_empty_flag    <= 1'b1;
      q.tx      <= 1'b1;
      q.rx_st   <= lmsc_pkg::LMSC_R_IDLE;
      q.tx_st   <= lmsc_pkg::LMSC_T_IDLE;
      q.hdr     <= lmsc_pkg::LMSC_H_NONE;
    end
    else
      q <= d;
  end

  assign o_rdata = q.rdata;
  assign o_tx    = q.tx;
  assign o_irq   = q.irq;

endmodule

// file: sim/lmsc_lin_serial_props.sv
`timescale 1ns/1ns
`include "lmsc_cfg.svh"
module lmsc_lin_serial_props (
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [1:0] i_cpu_mask,
  input wire logic       i_rx,
  input wire logic [7:0] o_rdata,
  input wire logic       o_tx,
  input wire logic       o_irq
);
  logic [7:0]  c3_q;
  logic        rie_q;
  logic [7:0]  baud_q;
  logic [7:0]  ext_q;
  logic [11:0] baud_divider_q;
  logic [23:0] lo_q;
  int          pr;
  int          tbit;
  // Register shadows and length of the current low run
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      c3_q   <= 8'h00;
      rie_q  <= 1'b0;
      baud_q <= 8'h00;
      ext_q  <= 8'h00;
      baud_divider_q <= `LMSC_RST_BAUD_DIVIDER;
      lo_q   <= 24'h000000;
    end
    else
    begin
      if (i_wr && i_addr == 4'h7) c3_q <= i_wdata;
      if (i_wr && i_addr == 4'h6) rie_q <= i_wdata[5];
      if (i_wr && i_addr == 4'h2) baud_q <= i_wdata;
      if (i_wr && i_addr == 4'h4) ext_q <= i_wdata;
      if (i_wr && i_addr == 4'h8) baud_divider_q[11:4] <= i_wdata;
      if (i_wr && i_addr == 4'h9) baud_divider_q[3:0] <= i_wdata[3:0];
      lo_q <= o_tx ? 24'h000000 : lo_q + 24'h000001;
    end
  end
  // Master bit time in clock cycles
  always_comb
  begin
    case (baud_q[7:6])
      2'h0: pr = 1;
      2'h1: pr = 3;
      2'h2: pr = 4;
      default: pr = 13;
    endcase
    tbit = 16 * pr * (1 << baud_q[5:3]) * (ext_q == 8'h00 ? 1 : int'(ext_q));
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_wr_c3;
    i_wr && i_addr == 4'h7;
  endsequence
  sequence s_rd_c3;
    i_rd && i_addr == 4'h7;
  endsequence
  property p_mode_rb;
    s_wr_c3 ##2 s_rd_c3 |=> o_rdata[7:3] == $past(i_wdata[7:3], 3);
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode bits readback");
  property p_ext_rb;
    i_rd && i_addr == 4'h4 |=> o_rdata == ext_q;
  endproperty
  a_ext_rb: assert property (p_ext_rb) else $error("tx prescaler readback");
  property p_unmap;
    i_rd && i_addr > 4'h9 |=> o_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rd_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_mst_brk;
    $rose(o_tx) && c3_q[7] && !c3_q[6] |-> lo_q <= 24'(13 * tbit);
  endproperty
  a_mst_brk: assert property (p_mst_brk) else $error("master low run too long");
  property p_slv_lo;
    $rose(o_tx) && c3_q[7] && c3_q[6] |-> lo_q <= 24'(9 * baud_divider_q + 1);
  endproperty
  a_slv_lo: assert property (p_slv_lo) else $error("slave low run too long");
  property p_irq_mask;
    i_cpu_mask != 2'b00 |=> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
  property p_irq_en;
    !rie_q && !c3_q[3] |=> !o_irq;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
endmodule
bind lmsc_lin_serial lmsc_lin_serial_props i_props (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cpu_mask(i_cpu_mask), .i_rx(i_rx), .o_rdata(o_rdata),
  .o_tx(o_tx), .o_irq(o_irq));

// file: sim/lmsc_lin_node.sv
`timescale 1ns/1ns
module lmsc_lin_node #(
  parameter int BIT_CYC = 16
) (
  input  wire logic i_clk,
  output logic      o_line
);
  // Recessive idle, pulled up
  initial o_line = 1'b1;
  task automatic send_brk();
    o_line <= 1'b0;
    repeat (13 * BIT_CYC) @(posedge i_clk);
    o_line <= 1'b1;
    repeat (BIT_CYC) @(posedge i_clk);
  endtask
  // Start, eight bits LSB first, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      o_line <= f[k];
      repeat (BIT_CYC) @(posedge i_clk);
    end
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int LB = 32;
  logic        i_core_clk;
  logic        i_rst;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [1:0]  i_cpu_mask;
  logic [7:0]  o_rdata;
  logic        o_tx;
  logic        o_irq;
  logic        node_line;
  logic        lin_bus;
  logic [15:0] d;
  logic [15:0] n;
  int          n_fail;
  int          comparisons;
  // Wired bus, dominant low wins
  assign lin_bus = node_line & o_tx;
  lmsc_lin_serial i_lmsc_lin_serial (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .i_cpu_mask (i_cpu_mask),
    .i_rx       (lin_bus),
    .o_rdata    (o_rdata),
    .o_tx       (o_tx),
    .o_irq      (o_irq)
  );
  lmsc_lin_node #(.BIT_CYC(LB)) i_lmsc_lin_node (
    .i_clk  (i_core_clk),
    .o_line (node_line)
  );
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask
  task automatic to();
    $display("[ERR] wait expected done seen timeout");
    n_fail++;
    end_of_test();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(posedge i_core_clk);
    d = {8'h00, o_rdata};
  endtask
  task automatic wait_st(input int bn);
    int k;
    for (k = 0; k < 400; k++)
    begin
      rd(4'h0);
      if (d[bn] === 1'b1) break;
    end
    if (k == 400) to();
  endtask
  // Length of the next low run on the transmit pin
  task automatic low_run();
    int k;
    n = 16'h0000;
    for (k = 0; k < 4000 && o_tx !== 1'b0; k++)
      @(posedge i_core_clk);
    if (k == 4000) to();
    for (k = 0; k < 4000 && o_tx === 1'b0; k++)
    begin
      @(posedge i_core_clk);
      n++;
    end
    if (k == 4000) to();
  endtask
  task automatic rx_one(input logic brk, input logic [7:0] b, input logic [7:0] st, input logic irq);
    if (brk)
      i_lmsc_lin_node.send_brk();
    else
      i_lmsc_lin_node.send_byte(b);
    wait_st(5);
    chk("rx status", {8'h00, st}, d);
    chk("rx irq", {15'h0000, irq}, {15'h0000, o_irq});
    rd(4'h1);
    chk("rx data", {8'h00, b}, d);
  endtask
  initial
  begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    i_rst = 1'b1;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_cpu_mask = 2'b00;
    n_fail = 0;
    comparisons = 0;
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd(4'h4);
    chk("tx prescaler reset", 16'h0000, d);
    rd(4'hF);
    chk("unmapped", 16'h0000, d);
    wr(4'h4, 8'hA5);
    rd(4'h4);
    chk("tx prescaler", 16'h00A5, d);
    $display("test registers done");
    wr(4'h5, 8'h04);
    wr(4'h7, 8'hC8);
    wr(4'h8, 8'h02);
    wr(4'h9, 8'h00);
    wr(4'h6, 8'h09);
    wr(4'h6, 8'h08);
    wr(4'h1, 8'h00);
    low_run();
    chk("slave low run", 16'(9 * LB), n);
    wr(4'h6, 8'h0C);
    rx_one(1'b1, 8'h00, 8'hA0, 1'b1);
    i_cpu_mask <= 2'b01;
    repeat (2) @(posedge i_core_clk);
    chk("masked irq", 16'h0000, {15'h0000, o_irq});
    i_cpu_mask <= 2'b00;
    rd(4'h7);
    chk("header flag", 16'h00CC, d);
    wr(4'h7, 8'hC8);
    rx_one(1'b0, 8'h55, 8'hA0, 1'b0);
    rx_one(1'b0, 8'h00, 8'hA1, 1'b0);
    rx_one(1'b1, 8'h00, 8'hA0, 1'b1);
    wr(4'h7, 8'hC0);
    rx_one(1'b0, 8'h55, 8'hA0, 1'b0);
    rx_one(1'b0, 8'h3C, 8'hA0, 1'b0);
    wr(4'h6, 8'h2C);
    rx_one(1'b1, 8'h00, 8'hA0, 1'b1);
    rx_one(1'b0, 8'hA5, 8'hA4, 1'b1);
    rd(4'h0);
    chk("header error cleared", 16'h0080, d);
    $display("test slave done");
    wr(4'h7, 8'h80);
    rd(4'h7);
    chk("master mode", 16'h0080, d);
    wr(4'h4, 8'h02);
    wr(4'h2, 8'h08);
    wr(4'h6, 8'h09);
    wr(4'h6, 8'h08);
    low_run();
    chk("break length", 16'(13 * 64), n);
    wr(4'h1, 8'h55);
    low_run();
    chk("start bit", 16'h0040, n);
    wait_st(7);
    wr(4'h1, 8'h3C);
    $display("test master done");
    end_of_test();
  end
endmodule
